// ---- include/rtc_ctl_pkg.sv ----
// Shared constants for the clock control, status and tamper logic.
package rtc_ctl_pkg;
	// Serial slave address and register offsets.
	localparam logic [6:0] SLAVE_ADDR = 7'h6f;
	localparam logic [7:0] ADDR_CLK_LAST = 8'h06;
	localparam logic [7:0] ADDR_SR = 8'h07;
	localparam logic [7:0] ADDR_INT = 8'h08;
	localparam logic [7:0] ADDR_EV = 8'h09;
	localparam logic [7:0] ADDR_TS0 = 8'h14;
	localparam logic [7:0] ADDR_TS_LAST = 8'h19;
	// Status register bit positions.
	localparam int SR_CF = 0;
	localparam int SR_BAT = 1;
	localparam int SR_ALM = 2;
	localparam int SR_TMP = 3;
	localparam int SR_GATE = 4;
	localparam int SR_OSC = 6;
	localparam int SR_AC = 7;
	// Pin control register bit positions.
	localparam int INT_FO_LSB = 0;
	localparam int INT_PINOFF = 4;
	localparam int INT_LP = 5;
	localparam int INT_ALON = 6;
	localparam int INT_REP = 7;
	// Tamper configuration bit positions.
	localparam int EV_SMP_LSB = 0;
	localparam int EV_DET_EN = 4;
	localparam int EV_OUT_BAT_OFF = 6;
	// Values after reset.
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] INT_RESET = 8'h00;
	localparam logic [7:0] EV_RESET = 8'h00;
	// Sampling codes of the tamper input.
	localparam logic [1:0] SMP_2HZ = 2'h1;
	localparam logic [1:0] SMP_1HZ = 2'h2;
	localparam logic [1:0] SMP_QHZ = 2'h3;
	// Time base and derived counts, in time base edges; POR_WAIT is in core cycles.
	localparam int TB_HZ = 32768;
	localparam int PULSE_MS = 250;
	localparam int PULSE_TB = TB_HZ * PULSE_MS / 1000;
	localparam int DIV_W = 20;
	localparam logic [1:0] POR_WAIT = 2'h3;
	// Divider bit that carries each selectable output frequency below the time base rate.
	function automatic logic [4:0] freq_bit(input logic [3:0] code);
		freq_bit = (code < 4'h4) ? 5'(2 * code - 2) : 5'(code + 4'h4);
	endfunction
endpackage

// ---- verilog/rtc_i2c_slave.sv ----
// Byte-level serial slave with register pointer and strobes.
`timescale 1ns/1ps
module rtc_i2c_slave import rtc_ctl_pkg::*; (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Serial pins.
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_oe,
	// Register side.
	output logic [7:0] reg_addr,
	input wire logic [7:0] rd_data,
	output logic rd_take,
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_first,
	output logic stop_seen
);
	typedef enum {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK} i2c_state_t;
	i2c_state_t st_q;
	logic [1:0] s1_q, s2_q, s3_q;
	logic [7:0] sh_q, out_q, ptr_q;
	logic [3:0] cnt_q;
	logic rw_q, ptr_ok_q, first_q, nack_q;
	// Both pins pass three flops; edges come from the second and third.
	always_ff @(posedge core_clk) begin
		s1_q <= {scl_pin, sda_in};
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	wire scl_rise = s2_q[1] & ~s3_q[1];
	wire scl_fall = ~s2_q[1] & s3_q[1];
	wire start_c = s2_q[1] & s3_q[1] & s3_q[0] & ~s2_q[0];
	wire stop_c = s2_q[1] & s3_q[1] & ~s3_q[0] & s2_q[0];
	wire load_c = scl_fall & ((st_q == S_AACK & rw_q) | (st_q == S_RACK & ~nack_q));
	assign reg_addr = ptr_q;
	assign rd_take = load_c;
	assign stop_seen = stop_c;
	// Bit engine; data changes on falling edges, sampled on rising ones.
	always_ff @(posedge core_clk) begin
		wr_stb <= 1'b0;
		if (reset) begin
			st_q <= S_IDLE;
			sda_oe <= 1'b0;
			{sh_q, out_q, ptr_q, cnt_q} <= '0;
			{rw_q, ptr_ok_q, first_q, nack_q} <= '0;
			{wr_addr, wr_data, wr_first} <= '0;
		end else if (start_c) begin
			st_q <= S_ADDR;
			cnt_q <= 4'h0;
			ptr_ok_q <= 1'b0;
			first_q <= 1'b1;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			st_q <= S_IDLE;
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			sh_q <= {sh_q[6:0], s2_q[0]};
			cnt_q <= cnt_q + 4'h1;
			nack_q <= s2_q[0];
		end else if (scl_fall) begin
			case (st_q)
				S_ADDR: if (cnt_q == 4'h8) begin
					st_q <= (sh_q[7:1] == SLAVE_ADDR) ? S_AACK : S_IDLE;
					sda_oe <= sh_q[7:1] == SLAVE_ADDR;
					rw_q <= sh_q[0];
				end
				S_WR: if (cnt_q == 4'h8) begin
					st_q <= S_WACK;
					sda_oe <= 1'b1;
					ptr_ok_q <= 1'b1;
					if (!ptr_ok_q) begin
						ptr_q <= sh_q;
					end else begin
						wr_stb <= 1'b1;
						{wr_addr, wr_data, wr_first} <= {ptr_q, sh_q, first_q};
						first_q <= 1'b0;
						ptr_q <= ptr_q + 8'h1;
					end
				end
				S_WACK: begin
					st_q <= S_WR;
					sda_oe <= 1'b0;
					cnt_q <= 4'h0;
				end
				S_AACK, S_RACK: begin
					st_q <= load_c ? S_RD : (rw_q | nack_q) ? S_IDLE : S_WR;
					sda_oe <= load_c & ~rd_data[7];
					out_q <= rd_data;
					cnt_q <= 4'h0;
					if (load_c) begin
						ptr_q <= ptr_q + 8'h1;
					end
				end
				S_RD: if (cnt_q == 4'h8) begin
					st_q <= S_RACK;
					sda_oe <= 1'b0;
				end else begin
					sda_oe <= ~out_q[6];
					out_q <= {out_q[6:0], 1'b0};
				end
				default: st_q <= st_q;
			endcase
		end
	end
endmodule

// ---- verilog/rtc_ctl_status.sv ----
// Control, status, alarm pin and tamper logic of the clock.
// Function
// - Clock-fail set after total power loss; clock write clears.
// - Backup flag sets on battery entry; write clears.
// - Alarm flag sets on enabled match; write clears.
// - Alarm during status read survives auto-clear.
// - Tamper event sets flag, pulls detect, stamps.
// - Tamper flag cleared by config write, zero, autoclear.
// - Only first stamp kept while flag set.
// - Clock writes need write gate; gate resets zero.
// - Clock starts and second aligns at STOP.
// - Oscillator-disable selects external time base.
// - Auto-clear clears three flags after status read.
// - Battery mode blocks single-byte pin control writes.
// - Four-bit code selects output frequency or off.
// - Nonzero frequency owns pin, disables alarm.
// - Pin-off bit silences pin on battery.
// - Low-power mode drops trip threshold condition.
// - Alarm-enable bit gates alarm matching.
// - Repeat mode pulses 250ms; else holds low.
// - Sampling code sets tamper check rate.
// - Detect-enable bit gates detection and stamping.
`timescale 1ns/1ps
module rtc_ctl_status import rtc_ctl_pkg::*; #(
	parameter int PULSE_LEN = PULSE_TB
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Serial pins.
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Time base pins.
	input wire logic osc_clk_pin,
	input wire logic ext_clk_pin,
	output logic osc_stop,
	// Supply monitor pins.
	input wire logic vdd_below_bat_pin,
	input wire logic vdd_below_trip_pin,
	input wire logic total_loss_pin,
	output logic on_battery,
	// Alarm comparator.
	input wire logic alarm_match,
	output logic alarm_armed,
	// Tamper input, detect pin and running time.
	input wire logic tamper_in_pin,
	input wire logic [47:0] cur_time,
	output logic detect_out_pin_out,
	output logic detect_out_pin_oe,
	// Interrupt or clock output pin.
	output logic alarm_clock_out_pin_out,
	output logic alarm_clock_out_pin_oe,
	// Timekeeping counters.
	output logic tk_wr_stb,
	output logic [7:0] tk_wr_addr,
	output logic [7:0] tk_wr_data,
	output logic clock_run,
	output logic sec_tick
);
	localparam int PW = $clog2(PULSE_LEN + 1);
	localparam int PULSE_FULL = PULSE_LEN;
	logic [5:0] s1_q, s2_q;
	logic [7:0] reg_addr, rd_data, wr_addr, wr_data;
	logic rd_take, wr_stb, wr_first, stop_seen;
	logic ac_q, osc_q, gate_q, cf_q, bat_q, alm_q, tmp_q;
	logic [7:0] int_q, ev_q;
	logic [47:0] ts_q;
	logic [DIV_W-1:0] div_q;
	logic [PW-1:0] pulse_q;
	logic [2:0] snap_q;
	logic [1:0] por_q;
	logic tb_prev_q, bat_prev_q, clk_wr_q, sr_rd_q, page_q, run_q, alm_late_q;

	// Serial protocol engine.
	rtc_i2c_slave u_slave (
		.core_clk(core_clk),
		.reset(reset),
		.scl_pin(scl_pin),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.reg_addr(reg_addr),
		.rd_data(rd_data),
		.rd_take(rd_take),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_first(wr_first),
		.stop_seen(stop_seen)
	);
	assign sda_out = 1'b0;

	// Pin inputs pass two flops before any logic reads them.
	always_ff @(posedge core_clk) begin
		s1_q <= {tamper_in_pin, vdd_below_bat_pin, vdd_below_trip_pin,
			total_loss_pin, ext_clk_pin, osc_clk_pin};
		s2_q <= s1_q;
	end
	wire osc_s = s2_q[0];
	wire ext_s = s2_q[1];
	wire loss_s = s2_q[2];
	wire trip_s = s2_q[3];
	wire hys_s = s2_q[4];
	wire tamper_s = s2_q[5];

	// Time base source and its rising edges.
	wire tb_lvl = osc_q ? ext_s : osc_s;
	wire tb_edge = tb_lvl & ~tb_prev_q;
	assign osc_stop = osc_q;

	// Supply switchover; low-power mode ignores the trip threshold.
	assign on_battery = hys_s & (int_q[INT_LP] | trip_s);
	wire bat_entry = on_battery & ~bat_prev_q;

	// Register write decode.
	wire sr_wr = wr_stb & (wr_addr == ADDR_SR);
	wire ev_wr = wr_stb & (wr_addr == ADDR_EV);
	wire clk_wr = wr_stb & (wr_addr <= ADDR_CLK_LAST) & gate_q;
	wire int_wr = wr_stb & (wr_addr == ADDR_INT) & (~on_battery | page_q);
	wire sr_rd = rd_take & (reg_addr == ADDR_SR);
	wire ac_stop = stop_seen & sr_rd_q & ac_q;

	// Frequency output; alarm is out of play while a frequency is chosen.
	wire [3:0] fo = int_q[INT_FO_LSB +: 4];
	wire fo_on = fo != 4'h0;
	wire wave = (fo == 4'h1) ? tb_lvl : div_q[freq_bit(fo)];
	assign alarm_armed = int_q[INT_ALON] & ~fo_on;

	// Flag set events.
	wire bat_set = bat_entry;
	wire alm_set = alarm_match & alarm_armed;
	wire smp_tick = (ev_q[1:0] == SMP_2HZ) ? tb_edge & (&div_q[13:0]) :
		(ev_q[1:0] == SMP_1HZ) ? tb_edge & (&div_q[14:0]) :
		(ev_q[1:0] == SMP_QHZ) ? tb_edge & (&div_q[16:0]) : 1'b1;
	wire tmp_hit = tamper_s & smp_tick & ev_q[EV_DET_EN];
	wire tmp_set = tmp_hit & ~tmp_q;

	// Flag clear terms; a set in the same cycle still wins.
	wire bat_clr = (sr_wr & ~wr_data[SR_BAT]) | (ac_stop & snap_q[0]);
	wire alm_clr = (sr_wr & ~wr_data[SR_ALM]) | (ac_stop & snap_q[1]);
	wire tmp_clr = ev_wr | (sr_wr & ~wr_data[SR_TMP]) | (ac_stop & snap_q[2]);

	// Status word as read; the reserved bit reads zero.
	wire [7:0] sr_val = {ac_q, osc_q, 1'b0, gate_q, tmp_q, alm_q, bat_q, cf_q};

	// Read mux; unmapped or foreign offsets read zero.
	wire [7:0] ts_idx = reg_addr - ADDR_TS0;
	wire in_ts = (reg_addr >= ADDR_TS0) & (reg_addr <= ADDR_TS_LAST);
	assign rd_data = (reg_addr == ADDR_SR) ? sr_val :
		(reg_addr == ADDR_INT) ? int_q :
		(reg_addr == ADDR_EV) ? ev_q :
		in_ts ? ts_q[ts_idx[2:0] * 8 +: 8] : 8'h00;

	// Control bits of the status register; all three start at zero.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			{ac_q, osc_q, gate_q} <= {SR_RESET[SR_AC], SR_RESET[SR_OSC], SR_RESET[SR_GATE]};
		end else if (sr_wr) begin
			{ac_q, osc_q, gate_q} <= {wr_data[SR_AC], wr_data[SR_OSC], wr_data[SR_GATE]};
		end
	end

	// Sticky flags; writes only ever clear them.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			{tmp_q, alm_q, bat_q} <= SR_RESET[SR_TMP:SR_BAT];
		end else begin
			bat_q <= bat_set | (bat_q & ~bat_clr);
			alm_q <= alm_set | (alm_q & ~alm_clr);
			tmp_q <= tmp_set | (tmp_q & ~tmp_clr);
		end
	end

	// Clock-fail flag is caught from the loss strap once the sync has settled.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			por_q <= 2'h0;
			cf_q <= SR_RESET[SR_CF];
		end else begin
			por_q <= (por_q == POR_WAIT) ? por_q : por_q + 2'h1;
			if (por_q == POR_WAIT - 2'h1) begin
				cf_q <= loss_s;
			end else if (clk_wr) begin
				cf_q <= 1'b0;
			end
		end
	end

	// Flags seen by a status read; a later set drops the bit from the clear.
	always_ff @(posedge core_clk) begin
		if (reset || stop_seen) begin
			snap_q <= 3'h0;
			sr_rd_q <= 1'b0;
		end else begin
			if (sr_rd) begin
				snap_q <= {tmp_q, alm_q, bat_q} & ~{tmp_set, alm_set, bat_set};
			end else begin
				snap_q <= snap_q & ~{tmp_set, alm_set, bat_set};
			end
			sr_rd_q <= sr_rd_q | sr_rd;
		end
	end

	// Marks an alarm that arrived after the status word was read in this transfer.
	always_ff @(posedge core_clk) begin
		if (reset || stop_seen) begin
			alm_late_q <= 1'b0;
		end else begin
			alm_late_q <= alm_late_q | ((sr_rd_q | sr_rd) & alm_set);
		end
	end

	// Transfer tracking: page start and valid clock writes.
	always_ff @(posedge core_clk) begin
		if (reset || stop_seen) begin
			page_q <= 1'b0;
			clk_wr_q <= 1'b0;
		end else begin
			if (wr_stb && wr_first) begin
				page_q <= wr_addr == ADDR_SR;
			end
			clk_wr_q <= clk_wr_q | clk_wr;
		end
	end

	// Pin control and tamper configuration registers.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			int_q <= INT_RESET;
			ev_q <= EV_RESET;
		end else begin
			if (int_wr) begin
				int_q <= wr_data;
			end
			if (ev_wr) begin
				ev_q <= wr_data;
			end
		end
	end

	// Time stamp keeps only the first event until the flag is cleared.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ts_q <= 48'h0;
		end else if (tmp_set) begin
			ts_q <= cur_time;
		end
	end

	// Timekeeping write strobe, passed on only with the gate open.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tk_wr_stb <= 1'b0;
			tk_wr_addr <= 8'h00;
			tk_wr_data <= 8'h00;
		end else begin
			tk_wr_stb <= clk_wr;
			tk_wr_addr <= wr_addr;
			tk_wr_data <= wr_data;
		end
	end

	// Divider; a clock write realigns the second at its STOP.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_q <= '0;
			tb_prev_q <= 1'b0;
			bat_prev_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			tb_prev_q <= tb_lvl;
			bat_prev_q <= on_battery;
			if (stop_seen && clk_wr_q) begin
				div_q <= '0;
				run_q <= 1'b1;
			end else if (tb_edge) begin
				div_q <= div_q + 1'b1;
			end
		end
	end
	assign clock_run = run_q;
	assign sec_tick = tb_edge & (&div_q[14:0]) & run_q;

	// Repeat-mode pulse length counted in time base edges, not core cycles.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_q <= '0;
		end else if (alm_set && int_q[INT_REP]) begin
			pulse_q <= PW'(PULSE_LEN);
		end else if (tb_edge && pulse_q != '0) begin
			pulse_q <= pulse_q - 1'b1;
		end
	end

	// Open-drain pins are driven only to pull low.
	wire pin_on = ~(int_q[INT_PINOFF] & on_battery);
	wire alarm_low = int_q[INT_ALON] & (int_q[INT_REP] ? pulse_q != '0 : alm_q);
	assign alarm_clock_out_pin_out = 1'b0;
	assign alarm_clock_out_pin_oe = pin_on & (fo_on ? ~wave : alarm_low);
	assign detect_out_pin_out = 1'b0;
	assign detect_out_pin_oe = tmp_q & ~(ev_q[EV_OUT_BAT_OFF] & on_battery);

	a_gate_after_reset: assert property (@(posedge core_clk) reset |=> !gate_q)
		else $error("write gate not zero after reset");
	a_clock_write_gated: assert property (@(posedge core_clk) disable iff (reset)
		tk_wr_stb |-> $past(gate_q))
		else $error("clock write passed with gate closed");
	a_alarm_no_write_set: assert property (@(posedge core_clk) disable iff (reset)
		(sr_wr && !alm_q && !alm_set) |=> !alm_q)
		else $error("write set the alarm flag");
	a_stamp_held: assert property (@(posedge core_clk) disable iff (reset)
		tmp_q ##1 tmp_q |-> $stable(ts_q))
		else $error("time stamp overwritten while flag set");
	a_detect_pulls_low: assert property (@(posedge core_clk) disable iff (reset)
		$rose(tmp_q) && !ev_q[EV_OUT_BAT_OFF] |-> detect_out_pin_oe)
		else $error("detect pin not pulled low on event");
	a_freq_blocks_alarm: assert property (@(posedge core_clk) disable iff (reset)
		fo_on && alarm_match |=> !$rose(alm_q))
		else $error("alarm set while frequency output on");
	a_pin_off_battery: assert property (@(posedge core_clk) disable iff (reset)
		int_q[INT_PINOFF] && on_battery |-> !alarm_clock_out_pin_oe)
		else $error("pin active on battery with pin-off set");
	a_single_hold: assert property (@(posedge core_clk) disable iff (reset)
		alm_q && int_q[INT_ALON] && !int_q[INT_REP] && !fo_on && pin_on
		|-> alarm_clock_out_pin_oe)
		else $error("single alarm not holding pin low");
	a_pulse_load: assert property (@(posedge core_clk) disable iff (reset)
		alm_set && int_q[INT_REP] |=> pulse_q == PW'(PULSE_FULL))
		else $error("repeat pulse not loaded to full length");
	a_auto_clear: assert property (@(posedge core_clk) disable iff (reset)
		ac_stop && snap_q[1] && !alm_set |=> !alm_q)
		else $error("alarm flag not auto-cleared");
	a_read_keeps_alarm: assert property (@(posedge core_clk) disable iff (reset)
		stop_seen && alm_late_q |=> alm_q)
		else $error("alarm set during read was lost");
	a_battery_int_block: assert property (@(posedge core_clk) disable iff (reset)
		wr_stb && wr_addr == ADDR_INT && on_battery && !page_q |=> $stable(int_q))
		else $error("single write to pin control on battery");
	a_tamper_ev_clear: assert property (@(posedge core_clk) disable iff (reset)
		ev_wr && !tmp_set |=> !tmp_q)
		else $error("tamper flag kept after config write");
	a_cf_clock_write: assert property (@(posedge core_clk) disable iff (reset)
		clk_wr && por_q == POR_WAIT |=> !cf_q)
		else $error("clock-fail flag kept after clock write");
endmodule

// ---- verification/i2c_host_model.sv ----
// Serial bus master model that drives the clock and data lines of the device.
`timescale 1ns/1ps
module i2c_host_model (
	// Clock.
	input wire logic core_clk,
	// Bus lines.
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// Idle bus: clock high, data released to its pull-up.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Half of the 80 ns serial period is ten core cycles.
	task automatic hc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Also serves as a repeated start, since it first releases data while the clock is low.
	task automatic start();
		sda_low = 1'b0;
		hc(5);
		scl = 1'b1;
		hc(10);
		sda_low = 1'b1;
		hc(10);
		scl = 1'b0;
		hc(5);
	endtask

	// Data moves only mid-way through the low phase, so it never looks like a start or stop.
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		hc(5);
		scl = 1'b1;
		hc(5);
		r = sda;
		hc(5);
		scl = 1'b0;
		hc(5);
	endtask

	// Eight data bits then the acknowledge bit; a read sends all ones to release the line.
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic nack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(last, nack);
	endtask

	// Stop: data rises while the clock is high, then the bus stays idle.
	task automatic stop();
		sda_low = 1'b1;
		hc(5);
		scl = 1'b1;
		hc(10);
		sda_low = 1'b0;
		hc(20);
	endtask
endmodule

// ---- verification/rtc_ctl_status_tb.sv ----
// Self-checking bench for the control, status, alarm pin and tamper logic.
`timescale 1ns/1ps
module rtc_ctl_status_tb import rtc_ctl_pkg::*; ();
	logic core_clk, reset, tl, vb, vt, am, tin, osc, ext, sda_low, scl;
	logic sda_oe, osc_stop, on_battery, alarm_armed, det_oe, pin_oe, tk_wr_stb, clock_run;
	logic [7:0] tk_wr_addr, tk_wr_data, d;
	logic [7:0] tk_n = 8'h00;
	logic [7:0] tk_a = 8'h00;
	logic [7:0] tk_d = 8'h00;
	logic [47:0] ct, t0;
	logic [7:0] q[$];
	wire logic sda;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	int seed;
	int n;

	// Open-drain data line with a pull-up: low if either party pulls.
	assign sda = ~(sda_low | sda_oe);

	i2c_host_model host (.core_clk(core_clk), .scl(scl), .sda_low(sda_low), .sda(sda));

	rtc_ctl_status #(.PULSE_LEN(16)) uut (.core_clk(core_clk), .reset(reset), .scl_pin(scl),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe), .osc_clk_pin(osc), .ext_clk_pin(ext),
		.osc_stop(osc_stop), .vdd_below_bat_pin(vb), .vdd_below_trip_pin(vt),
		.total_loss_pin(tl), .on_battery(on_battery), .alarm_match(am),
		.alarm_armed(alarm_armed), .tamper_in_pin(tin), .cur_time(ct),
		.detect_out_pin_out(), .detect_out_pin_oe(det_oe), .alarm_clock_out_pin_out(),
		.alarm_clock_out_pin_oe(pin_oe), .tk_wr_stb(tk_wr_stb), .tk_wr_addr(tk_wr_addr),
		.tk_wr_data(tk_wr_data), .clock_run(clock_run), .sec_tick());

	// Core clock, and a fast stand-in time base whose edges fall on core falling edges.
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		osc = 1'b0;
		#4;
		forever #200 osc = ~osc;
	end
	// External time base, faster than the crystal stand-in so the two can be told apart.
	initial begin
		ext = 1'b0;
		forever #120 ext = ~ext;
	end

	// Records timekeeping writes and cuts a hung run short.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (tk_wr_stb === 1'b1) begin
			tk_n <= tk_n + 8'h01;
			tk_a <= tk_wr_addr;
			tk_d <= tk_wr_data;
		end
		if (cyc == 80000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic w(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	// Register write: address byte, pointer, then data at ascending addresses.
	task automatic wr(input logic [7:0] a, input logic [7:0] dq[$]);
		logic [7:0] r;
		logic nk;
		logic bad;
		host.start();
		host.xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, bad);
		host.xfer(a, 1'b1, r, nk);
		bad |= nk;
		foreach (dq[i]) begin
			host.xfer(dq[i], 1'b1, r, nk);
			bad |= nk;
		end
		host.stop();
		chk("ack", 0, bad);
	endtask

	// Register read; mid raises an alarm match after the data but before the stop.
	task automatic rd(input logic [7:0] a, input int cnt, input logic mid,
		output logic [7:0] rq[$]);
		logic [7:0] r;
		logic nk;
		rq = {};
		host.start();
		host.xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, nk);
		host.xfer(a, 1'b1, r, nk);
		host.start();
		host.xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, nk);
		for (int i = 0; i < cnt; i++) begin
			host.xfer(8'hff, i == cnt - 1, r, nk);
			rq.push_back(r);
		end
		if (mid) begin
			pulse_alarm();
		end
		host.stop();
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] rq[$];
		rd(a, 1, 1'b0, rq);
		chk(nm, e, rq[0]);
	endtask

	task automatic pulse_alarm();
		am = 1'b1;
		w(1);
		am = 1'b0;
	endtask

	task automatic tamper();
		tin = 1'b1;
		w(20);
		tin = 1'b0;
		w(10);
	endtask

	// The stamp model packs the six bytes as the running time does, seconds lowest.
	task automatic stamp(input logic [47:0] e);
		logic [7:0] rq[$];
		logic [47:0] g;
		rd(ADDR_TS0, 6, 1'b0, rq);
		foreach (rq[i]) begin
			g[8*i +: 8] = rq[i];
		end
		chk("stamp", e, g);
	endtask

	// Counts pin transitions over a window that spans several time base periods.
	task automatic tog(output int k);
		logic p;
		k = 0;
		p = pin_oe;
		repeat (400) begin
			w(1);
			if (pin_oe !== p) k++;
			p = pin_oe;
		end
	endtask

	// Main sequence; totally lost supplies are reported from power-up.
	initial begin
		seed = 38972;
		reset = 1'b1;
		tl = 1'b1;
		{vb, vt, am, tin} = 4'h0;
		ct = 48'h000000000000;
		w(12);
		reset = 1'b0;
		w(4);
		rc("sr_reset", ADDR_SR, 8'h01);
		d = 8'($random(seed));
		wr(8'h00, '{d});
		chk("run_gated", {tk_n, 7'h00, clock_run}, 0);
		wr(ADDR_SR, '{8'h10});
		rc("sr_gate", ADDR_SR, 8'h11);
		wr(8'h00, '{d});
		chk("tk_write", {8'h01, 8'h00, d, 7'h00, clock_run}, {tk_n, tk_a, tk_d, 8'h01});
		rc("sr_cf_clear", ADDR_SR, 8'h10);
		wr(ADDR_SR, '{8'h70});
		rc("sr_reserved", ADDR_SR, 8'h50);
		chk("osc_stop", 1, osc_stop);
		wr(ADDR_INT, '{8'h01});
		tog(n);
		chk("ext_base", 1, n > 10);
		wr(ADDR_INT, '{8'h00});
		wr(ADDR_SR, '{8'h10});
		chk("osc_run", 0, osc_stop);
		// Low-power mode is only written while the supply pins show main power.
		for (int lp = 1; lp >= 0; lp--) begin
			wr(ADDR_INT, '{8'(lp << 5)});
			for (int p = 0; p < 4; p++) begin
				{vb, vt} = 2'(p);
				w(6);
				chk("on_battery", vb & (vt | lp[0]), on_battery);
			end
			{vb, vt} = 2'b00;
			w(6);
		end
		rc("sr_bat", ADDR_SR, 8'h12);
		wr(ADDR_SR, '{8'h10});
		wr(ADDR_SR, '{8'h12});
		rc("sr_bat_clear", ADDR_SR, 8'h10);
		{vb, vt} = 2'b11;
		w(6);
		wr(ADDR_INT, '{8'h0a});
		rc("int_single", ADDR_INT, 8'h00);
		wr(ADDR_SR, '{8'h10, 8'h11});
		tog(n);
		chk("pin_off", 0, {n != 0, pin_oe});
		wr(ADDR_SR, '{8'h10, 8'h01});
		tog(n);
		chk("pin_freq", 1, n > 2 && n < 10);
		{vb, vt} = 2'b00;
		w(6);
		wr(ADDR_SR, '{8'h10, 8'h00});
		chk("armed_off", 0, alarm_armed);
		for (int c = 1; c < 16; c++) begin
			wr(ADDR_INT, '{8'h40 | 8'(c)});
			chk("armed_freq", 0, alarm_armed);
			pulse_alarm();
		end
		rc("sr_freq_alarm", ADDR_SR, 8'h10);
		wr(ADDR_INT, '{8'h40});
		chk("armed", 1, alarm_armed);
		pulse_alarm();
		w(4);
		chk("pin_single", 1, pin_oe);
		wr(ADDR_SR, '{8'h14});
		rc("sr_alarm", ADDR_SR, 8'h14);
		wr(ADDR_SR, '{8'h10});
		chk("pin_release", 0, pin_oe);
		wr(ADDR_SR, '{8'h90});
		rd(ADDR_SR, 1, 1'b1, q);
		rc("sr_mid_read", ADDR_SR, 8'h94);
		rc("sr_auto", ADDR_SR, 8'h90);
		wr(ADDR_INT, '{8'hc0});
		pulse_alarm();
		w(680);
		chk("pulse_low", 1, pin_oe);
		w(1020);
		chk("pulse_end", 0, pin_oe);
		wr(ADDR_SR, '{8'h10, 8'h00});
		tamper();
		rc("sr_tamper_off", ADDR_SR, 8'h10);
		wr(ADDR_EV, '{8'h10});
		ct = 48'({$random(seed), $random(seed)});
		t0 = ct;
		tamper();
		chk("detect", 1, det_oe);
		rc("sr_tamper", ADDR_SR, 8'h18);
		ct = ~t0;
		tamper();
		stamp(t0);
		wr(ADDR_SR, '{8'h10});
		chk("detect_clear", 0, det_oe);
		tamper();
		stamp(~t0);
		wr(ADDR_EV, '{8'h11});
		rc("sr_ev_write", ADDR_SR, 8'h10);
		tamper();
		rc("sr_slow", ADDR_SR, 8'h10);
		summarize();
	end
endmodule
